/* File: logic/sdg_pkg.sv */
// shared constants and types for the socket detect and global control block
package sdg_pkg;

  localparam int unsigned SDG_ADDR_W = 12;
  localparam int unsigned SDG_DATA_W = 8;

  localparam logic [SDG_ADDR_W-1:0] SDG_DETECT_OFFSET = 12'h816;
  localparam logic [SDG_ADDR_W-1:0] SDG_GLOBAL_OFFSET = 12'h81e;

  // card detect and general control bit positions
  localparam int unsigned SDG_DET_SENSE_TWO_BIT = 7;
  localparam int unsigned SDG_DET_SENSE_ONE_BIT = 6;
  localparam int unsigned SDG_DET_SW_IRQ_BIT = 5;
  localparam int unsigned SDG_DET_RESUME_BIT = 4;
  localparam int unsigned SDG_DET_REMOVAL_BIT = 1;

  // global control bit positions
  localparam int unsigned SDG_GLB_SPARE_BIT = 4;
  localparam int unsigned SDG_GLB_HOST_LVL_BIT = 3;
  localparam int unsigned SDG_GLB_CLEAR_BIT = 2;
  localparam int unsigned SDG_GLB_CSC_LVL_BIT = 1;
  localparam int unsigned SDG_GLB_PWRDN_BIT = 0;

  localparam logic [SDG_DATA_W-1:0] SDG_READ_IDLE = 8'h00;
  localparam logic [1:0] SDG_DETECT_BOTH_PRESENT = 2'h0;
  // cycles after reset before detect history counts; covers the synchroniser delay
  localparam logic [2:0] SDG_SETTLE_CYCLES = 3'h6;

  typedef struct packed {
    logic detect_resume_enable;
    logic removal_register_reset;
  } sdg_detect_ctl_t;

  typedef struct packed {
    logic spare;
    logic host_irq_level_select;
    logic flag_clear_method;
    logic status_change_irq_level_select;
    logic socket_power_down;
  } sdg_global_ctl_t;

  localparam sdg_detect_ctl_t SDG_DETECT_CTL_RESET = 2'h0;
  localparam sdg_global_ctl_t SDG_GLOBAL_CTL_RESET = 5'h00;

endpackage

/* File: logic/sdg_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sdg_sync3
  import sdg_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
          stage3_reg[i] <= 1'b0;
          level_reg[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= pin_in[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          // stage1 is seen only by stage2; a change counts once 2 and 3 agree
          if (stage2_reg[i] == stage3_reg[i]) begin
            level_reg[i] <= stage3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign level_out = level_reg;

endmodule

/* File: logic/sdg_detect_events.sv */
// card detect change and removal event detector
`timescale 1ns/1ps
module sdg_detect_events
  import sdg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [1:0] detect_level_in,
  output logic change_out,
  output logic removal_out
);

  logic [1:0] prev_reg;
  logic [2:0] settle_reg;
  logic primed;
  logic change_reg;
  logic removal_reg;
  logic change_next;
  logic removal_next;

  // the synchronisers leave reset at zero, which reads as a seated card; events
  // wait until the first real pin level has come through, so an empty socket
  // at reset does not look like a removal
  assign primed = (settle_reg == SDG_SETTLE_CYCLES);
  assign change_next = primed && (detect_level_in != prev_reg);
  assign removal_next = primed && (prev_reg == SDG_DETECT_BOTH_PRESENT) &&
                        (detect_level_in != SDG_DETECT_BOTH_PRESENT);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      prev_reg <= 2'h0;
      settle_reg <= 3'h0;
      change_reg <= 1'b0;
      removal_reg <= 1'b0;
    end else begin
      prev_reg <= detect_level_in;
      if (!primed) begin
        settle_reg <= settle_reg + 3'h1;
      end
      change_reg <= change_next;
      removal_reg <= removal_next;
    end
  end

  assign change_out = change_reg;
  assign removal_out = removal_reg;

endmodule

/* File: logic/sdg_socket_ctrl.sv */
// socket card detect / general control and global control registers
`timescale 1ns/1ps
module sdg_socket_ctrl
  import sdg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [SDG_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [SDG_DATA_W-1:0] reg_wdata_in,
  output logic [SDG_DATA_W-1:0] reg_rdata_out,
  input wire logic voltage_sense_first_in,
  input wire logic voltage_sense_second_in,
  input wire logic card_present_input_a_in,
  input wire logic card_present_input_b_in,
  input wire logic detect_change_irq_enable_in,
  input wire logic status_flag_clear_in,
  input wire logic card_cycle_active_in,
  input wire logic card_dma_request_in,
  input wire logic card_irq_in,
  output logic ring_indicate_output_out,
  output logic sw_detect_irq_out,
  output logic removal_reset_out,
  output logic card_drive_enable_out,
  output logic card_dma_request_out,
  output logic card_irq_out,
  output logic host_irq_level_select_out,
  output logic flag_clear_method_out,
  output logic status_change_irq_level_select_out,
  output logic socket_power_down_out
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and detect events

  logic [1:0] sense_level;
  logic [1:0] detect_level;
  logic [1:0] event_level;
  logic detect_change;
  logic card_removed;

  sdg_sync3 #(.WIDTH(2)) u_sense_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in({voltage_sense_second_in, voltage_sense_first_in}),
    .level_out(sense_level)
  );

  sdg_sync3 #(.WIDTH(2)) u_detect_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in({card_present_input_b_in, card_present_input_a_in}),
    .level_out(detect_level)
  );

  sdg_sync3 #(.WIDTH(2)) u_event_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in({card_irq_in, card_dma_request_in}),
    .level_out(event_level)
  );

  sdg_detect_events u_events (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .detect_level_in(detect_level),
    .change_out(detect_change),
    .removal_out(card_removed)
  );

  ////////////////////////////////////////////////////////////////////////
  // register decode

  sdg_detect_ctl_t detect_ctl_reg;
  sdg_detect_ctl_t detect_ctl_next;
  sdg_global_ctl_t global_ctl_reg;
  sdg_global_ctl_t global_ctl_next;
  logic [SDG_DATA_W-1:0] rdata_reg;
  logic [SDG_DATA_W-1:0] rdata_next;
  logic [SDG_DATA_W-1:0] detect_view;
  logic [SDG_DATA_W-1:0] global_view;
  logic hit_detect;
  logic hit_global;
  logic write_detect;
  logic write_global;

  assign hit_detect = (reg_addr_in == SDG_DETECT_OFFSET);
  assign hit_global = (reg_addr_in == SDG_GLOBAL_OFFSET);
  assign write_detect = reg_write_in && hit_detect;
  assign write_global = reg_write_in && hit_global;

  assign detect_ctl_next = write_detect ?
    sdg_detect_ctl_t'{detect_resume_enable: reg_wdata_in[SDG_DET_RESUME_BIT],
      removal_register_reset: reg_wdata_in[SDG_DET_REMOVAL_BIT]} :
    detect_ctl_reg;
  assign global_ctl_next = write_global ?
    sdg_global_ctl_t'{spare: reg_wdata_in[SDG_GLB_SPARE_BIT],
      host_irq_level_select: reg_wdata_in[SDG_GLB_HOST_LVL_BIT],
      flag_clear_method: reg_wdata_in[SDG_GLB_CLEAR_BIT],
      status_change_irq_level_select: reg_wdata_in[SDG_GLB_CSC_LVL_BIT],
      socket_power_down: reg_wdata_in[SDG_GLB_PWRDN_BIT]} :
    global_ctl_reg;

  // sense bits are live pin levels; software irq bit is write-only
  always_comb begin
    detect_view = SDG_READ_IDLE;
    detect_view[SDG_DET_SENSE_TWO_BIT] = sense_level[1];
    detect_view[SDG_DET_SENSE_ONE_BIT] = sense_level[0];
    detect_view[SDG_DET_RESUME_BIT] = detect_ctl_reg.detect_resume_enable;
    detect_view[SDG_DET_REMOVAL_BIT] = detect_ctl_reg.removal_register_reset;
  end

  always_comb begin
    global_view = SDG_READ_IDLE;
    global_view[SDG_GLB_SPARE_BIT] = global_ctl_reg.spare;
    global_view[SDG_GLB_HOST_LVL_BIT] = global_ctl_reg.host_irq_level_select;
    global_view[SDG_GLB_CLEAR_BIT] = global_ctl_reg.flag_clear_method;
    global_view[SDG_GLB_CSC_LVL_BIT] = global_ctl_reg.status_change_irq_level_select;
    global_view[SDG_GLB_PWRDN_BIT] = global_ctl_reg.socket_power_down;
  end

  // unmapped reads answer zero; read data holds until the next read
  assign rdata_next = !reg_read_in ? rdata_reg :
                      hit_detect ? detect_view :
                      hit_global ? global_view : SDG_READ_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // detect side effects

  logic sw_irq_reg;
  logic sw_irq_next;
  logic ring_low_reg;
  logic ring_low_next;
  logic removal_reset_reg;
  logic removal_reset_next;

  // a software request with the detect interrupt disabled is dropped
  assign sw_irq_next = write_detect && reg_wdata_in[SDG_DET_SW_IRQ_BIT] &&
                       detect_change_irq_enable_in;

  // a new change arriving with the clear wins, so no resume is lost
  assign ring_low_next =
    (detect_ctl_reg.detect_resume_enable && detect_change) ? 1'b1 :
    status_flag_clear_in ? 1'b0 : ring_low_reg;

  // the removal reset leaves this block's own settings untouched
  assign removal_reset_next = card_removed &&
                              detect_ctl_reg.removal_register_reset;

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      detect_ctl_reg <= SDG_DETECT_CTL_RESET;
      global_ctl_reg <= SDG_GLOBAL_CTL_RESET;
      rdata_reg <= SDG_READ_IDLE;
      sw_irq_reg <= 1'b0;
      ring_low_reg <= 1'b0;
      removal_reset_reg <= 1'b0;
    end else begin
      detect_ctl_reg <= detect_ctl_next;
      global_ctl_reg <= global_ctl_next;
      rdata_reg <= rdata_next;
      sw_irq_reg <= sw_irq_next;
      ring_low_reg <= ring_low_next;
      removal_reset_reg <= removal_reset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = rdata_reg;
  assign ring_indicate_output_out = !ring_low_reg;
  assign sw_detect_irq_out = sw_irq_reg;
  assign removal_reset_out = removal_reset_reg;
  assign host_irq_level_select_out = global_ctl_reg.host_irq_level_select;
  assign flag_clear_method_out = global_ctl_reg.flag_clear_method;
  assign status_change_irq_level_select_out =
    global_ctl_reg.status_change_irq_level_select;
  assign socket_power_down_out = global_ctl_reg.socket_power_down;

  // outputs float in power down except while a card cycle runs
  assign card_drive_enable_out = !global_ctl_reg.socket_power_down ||
                                 card_cycle_active_in;
  // requests pass whatever the power state; only accesses wake the card
  assign card_dma_request_out = event_level[0];
  assign card_irq_out = event_level[1];

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sense_two_a: assert property (
    reg_read_in && hit_detect |=>
      reg_rdata_out[SDG_DET_SENSE_TWO_BIT] == $past(sense_level[1]))
    else $error("sense two bit mismatch");

  sense_one_a: assert property (
    reg_read_in && hit_detect |=>
      reg_rdata_out[SDG_DET_SENSE_ONE_BIT] == $past(sense_level[0]))
    else $error("sense one bit mismatch");

  sw_irq_a: assert property (
    write_detect && reg_wdata_in[SDG_DET_SW_IRQ_BIT] &&
    detect_change_irq_enable_in |=> sw_detect_irq_out ##1 !sw_detect_irq_out ||
    $past(sw_irq_next))
    else $error("software detect irq missing");

  sw_quiet_a: assert property (
    !(write_detect && detect_change_irq_enable_in) |=> !sw_detect_irq_out)
    else $error("spurious software detect irq");

  sw_readzero_a: assert property (
    reg_read_in && hit_detect |=> !reg_rdata_out[SDG_DET_SW_IRQ_BIT])
    else $error("software irq bit read nonzero");

  resume_low_a: assert property (
    detect_ctl_reg.detect_resume_enable && detect_change |=>
      !ring_indicate_output_out)
    else $error("ring not driven low on resume");

  ring_hold_a: assert property (
    !ring_indicate_output_out && !status_flag_clear_in |=> !ring_indicate_output_out)
    else $error("ring released without flag clear");

  resume_off_a: assert property (
    $fell(ring_indicate_output_out) |->
      $past(detect_ctl_reg.detect_resume_enable && detect_change))
    else $error("ring fell without enabled resume");

  removal_cfg_a: assert property (
    card_removed |=> removal_reset_out == $past(detect_ctl_reg.removal_register_reset))
    else $error("removal reset selection wrong");

  detect_rsvd_a: assert property (
    reg_read_in && hit_detect |=> reg_rdata_out[3:2] == 2'h0 && !reg_rdata_out[0])
    else $error("detect reserved bits nonzero");

  global_rsvd_a: assert property (
    reg_read_in && hit_global |=> reg_rdata_out[7:5] == 3'h0)
    else $error("global reserved bits nonzero");

  spare_bit_a: assert property (
    write_global ##1 (reg_read_in && hit_global && !reg_write_in) |=>
      reg_rdata_out[SDG_GLB_SPARE_BIT] == $past(reg_wdata_in[SDG_GLB_SPARE_BIT], 2))
    else $error("spare bit not stored");

  host_mode_a: assert property (
    write_global |=> host_irq_level_select_out == $past(reg_wdata_in[SDG_GLB_HOST_LVL_BIT]))
    else $error("host irq mode not updated");

  clear_mode_a: assert property (
    write_global |=> flag_clear_method_out == $past(reg_wdata_in[SDG_GLB_CLEAR_BIT]))
    else $error("flag clear method not updated");

  csc_mode_a: assert property (
    write_global |=>
      status_change_irq_level_select_out == $past(reg_wdata_in[SDG_GLB_CSC_LVL_BIT]))
    else $error("status change irq mode not updated");

  power_float_a: assert property (
    socket_power_down_out && !card_cycle_active_in |-> !card_drive_enable_out)
    else $error("card outputs driven in power down");

  power_events_a: assert property (
    socket_power_down_out && card_removed && detect_ctl_reg.removal_register_reset
      |=> removal_reset_out)
    else $error("events blocked in power down");

  removal_time_a: assert property (
    removal_reset_out |-> $past(card_removed) && !$past(card_removed, 2))
    else $error("removal reset timing wrong");

  removal_pulse_a: assert property (
    removal_reset_out |=>
      !removal_reset_out)
    else $error("removal reset longer than one cycle");

  resume_store_a: assert property (
    write_detect |=>
      detect_ctl_reg.detect_resume_enable == $past(reg_wdata_in[SDG_DET_RESUME_BIT]))
    else $error("resume enable not stored");

  removal_store_a: assert property (
    write_detect |=>
      detect_ctl_reg.removal_register_reset == $past(reg_wdata_in[SDG_DET_REMOVAL_BIT]))
    else $error("removal selection not stored");

  removal_off_a: assert property (
    !detect_ctl_reg.removal_register_reset |=>
      !removal_reset_out)
    else $error("removal reset while not selected");

  ring_quiet_a: assert property (
    ring_indicate_output_out && !detect_ctl_reg.detect_resume_enable |=>
      ring_indicate_output_out)
    else $error("ring fell with resume disabled");

  ring_release_a: assert property (
    !ring_indicate_output_out && status_flag_clear_in &&
      !(detect_ctl_reg.detect_resume_enable && detect_change) |=> ring_indicate_output_out)
    else $error("ring not released by flag clear");

  global_hold_a: assert property (
    !write_global |=>
      $stable(global_ctl_reg))
    else $error("global control changed without write");

  power_store_a: assert property (
    write_global |=>
      socket_power_down_out == $past(reg_wdata_in[SDG_GLB_PWRDN_BIT]))
    else $error("power down bit not updated");

  power_wake_a: assert property (
    card_cycle_active_in |->
      card_drive_enable_out)
    else $error("card outputs floated during a card cycle");

  power_off_a: assert property (
    !socket_power_down_out |->
      card_drive_enable_out)
    else $error("card outputs floated outside power down");

endmodule

/* File: testbench/sdg_card_model.sv */
// card-side model: detect, voltage sense and request pins of a card in the socket
`timescale 1ns/1ps
module sdg_card_model (
  input wire logic seated_in,
  input wire logic vs_first_in,
  input wire logic vs_second_in,
  input wire logic dma_in,
  input wire logic irq_in,
  output logic present_a_out,
  output logic present_b_out,
  output logic vs_first_out,
  output logic vs_second_out,
  output logic dma_out,
  output logic irq_out
);
  // an empty socket leaves every card pin to its pull-up
  assign present_a_out = !seated_in;
  assign present_b_out = !seated_in;
  assign vs_first_out = seated_in ? vs_first_in : 1'b1;
  assign vs_second_out = seated_in ? vs_second_in : 1'b1;
  assign dma_out = seated_in ? dma_in : 1'b1;
  assign irq_out = seated_in ? irq_in : 1'b1;
endmodule

/* File: testbench/sdg_socket_ctrl_tb_top.sv */
// self-checking bench for the socket detect and global control registers
`timescale 1ns/1ps
module sdg_socket_ctrl_tb_top;
  import sdg_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] lv;
  } sdg_row_t;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic seated = 1'b1;
  logic dma = 1'b0;
  logic irq = 1'b0;
  logic irq_en = 1'b0;
  logic clr = 1'b0;
  logic active = 1'b0;
  logic vs_a = 1'b0;
  logic vs_b = 1'b1;
  logic vs1, vs2, pa, pb, dma_p, irq_p, ring, sw_irq, rem, drv, dma_o, irq_o, hl, fc, cl, pd;
  logic [7:0] d;
  int n_fail = 0;
  int checks = 0;
  sdg_row_t rows [6] = '{'{12'h81e, 8'hff, 8'h1f, 4'hf}, '{12'h816, 8'hff, 8'h92, 4'hf},
    '{12'h817, 8'hff, 8'h00, 4'hf}, '{12'h81e, 8'h15, 8'h15, 4'h5},
    '{12'h81e, 8'h00, 8'h00, 4'h0}, '{12'h816, 8'h00, 8'h80, 4'h0}};

  initial begin
    forever #25 clock_in = ~clock_in;
  end

  sdg_card_model card (.seated_in(seated), .vs_first_in(vs_a), .vs_second_in(vs_b),
    .dma_in(dma), .irq_in(irq), .present_a_out(pa), .present_b_out(pb),
    .vs_first_out(vs1), .vs_second_out(vs2), .dma_out(dma_p), .irq_out(irq_p));

  sdg_socket_ctrl dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .voltage_sense_first_in(vs1), .voltage_sense_second_in(vs2),
    .card_present_input_a_in(pa), .card_present_input_b_in(pb),
    .detect_change_irq_enable_in(irq_en), .status_flag_clear_in(clr),
    .card_cycle_active_in(active), .card_dma_request_in(dma_p), .card_irq_in(irq_p),
    .ring_indicate_output_out(ring), .sw_detect_irq_out(sw_irq), .removal_reset_out(rem),
    .card_drive_enable_out(drv), .card_dma_request_out(dma_o), .card_irq_out(irq_o),
    .host_irq_level_select_out(hl), .flag_clear_method_out(fc),
    .status_change_irq_level_select_out(cl), .socket_power_down_out(pd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock_in);
    wr_en <= 1'b0;
  endtask

  // rdata is registered: settled just after the edge that takes the read
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  // watch that no removal pulse and no ring fall appear for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock_in);
      #1;
      chk1("ring_quiet", 1'b1, ring);
      chk1("removal_quiet", 1'b0, rem);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1;
    chk1("ring_reset", 1'b1, ring);
    chk1("drive_reset", 1'b1, drv);
    repeat (6) @(posedge clock_in);
    rd(12'h81e, d);
    chk8("global_reset", 8'h00, d);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      #1;
      chk1("sw_irq_disabled", 1'b0, sw_irq);
      rd(rows[i].addr, d);
      chk8("row_read", rows[i].rdata, d);
      chk8("row_levels", {4'h0, rows[i].lv}, {4'h0, hl, fc, cl, pd});
    end
    // software detect interrupt with the enable set
    @(posedge clock_in);
    irq_en <= 1'b1;
    wr(12'h816, 8'h20);
    #1;
    chk1("sw_irq_pulse", 1'b1, sw_irq);
    @(posedge clock_in);
    #1;
    chk1("sw_irq_end", 1'b0, sw_irq);
    rd(12'h816, d);
    chk8("sw_bit_reads_zero", 8'h80, d);
    // removal with resume and register reset selected
    wr(12'h816, 8'h12);
    @(posedge clock_in);
    seated <= 1'b0;
    begin : wait_ring
      for (int i = 0; i < 20; i++) begin
        @(posedge clock_in);
        #1;
        if (ring === 1'b0) disable wait_ring;
      end
      n_fail++;
      $display("[ERR] ring_fall expected 0 seen %b", ring);
      give_verdict();
    end
    chk1("ring_low", 1'b0, ring);
    chk1("removal_pulse", 1'b1, rem);
    @(posedge clock_in);
    #1;
    chk1("removal_end", 1'b0, rem);
    rd(12'h816, d);
    chk8("settings_kept", 8'hd2, d);
    repeat (4) @(posedge clock_in);
    #1;
    chk1("ring_held", 1'b0, ring);
    @(posedge clock_in);
    clr <= 1'b1;
    @(posedge clock_in);
    clr <= 1'b0;
    #1;
    chk1("ring_release", 1'b1, ring);
    // resume and removal reset both off
    wr(12'h816, 8'h00);
    @(posedge clock_in);
    seated <= 1'b1;
    quiet(12);
    @(posedge clock_in);
    seated <= 1'b0;
    quiet(12);
    @(posedge clock_in);
    seated <= 1'b1;
    quiet(8);
    // back-to-back write then read of the global register
    @(posedge clock_in);
    addr <= 12'h81e;
    wdata <= 8'h10;
    wr_en <= 1'b1;
    @(posedge clock_in);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
    #1;
    chk8("spare_b2b", 8'h10, rdata);
    // power down floats card outputs outside a card cycle, still passes requests
    wr(12'h81e, 8'h01);
    @(posedge clock_in);
    dma <= 1'b1;
    irq <= 1'b1;
    #1;
    chk1("drive_off", 1'b0, drv);
    @(posedge clock_in);
    active <= 1'b1;
    #1;
    chk1("drive_cycle", 1'b1, drv);
    @(posedge clock_in);
    active <= 1'b0;
    #1;
    chk1("drive_after", 1'b0, drv);
    repeat (6) @(posedge clock_in);
    #1;
    chk1("dma_pass", 1'b1, dma_o);
    chk1("irq_pass", 1'b1, irq_o);
    @(posedge clock_in);
    dma <= 1'b0;
    irq <= 1'b0;
    repeat (6) @(posedge clock_in);
    #1;
    chk1("dma_drop", 1'b0, dma_o);
    chk1("irq_drop", 1'b0, irq_o);
    // swapped sense levels: second sense pin low, first high
    @(posedge clock_in);
    vs_a <= 1'b1;
    vs_b <= 1'b0;
    repeat (6) @(posedge clock_in);
    rd(12'h816, d);
    chk8("sense_swap", 8'h40, d);
    // reset in mid-run clears the control bits
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(12'h81e, d);
    chk8("global_rereset", 8'h00, d);
    chk1("drive_rereset", 1'b1, drv);
    give_verdict();
  end
endmodule
